//--- frs_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module frs_array_model (
  input  wire logic        i_clk,
  input  wire logic        i_pgm,
  input  wire logic        i_erase,
  input  wire logic        i_hv,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_stb,
  input  wire logic        i_standby,
  input  wire logic [7:0]  i_prot,
  output logic [7:0]       o_protect_start
);
  logic [7:0] mem [64];
  int         n_prog = 0;
  int         n_bad  = 0;

  assign o_protect_start = i_prot;

  // Cells of one row start erased
  initial begin
    foreach (mem[k]) mem[k] = 8'hFF;
  end

  always @(posedge i_clk) begin
    if (i_standby && (i_pgm || i_erase || i_hv || i_stb)) begin
      n_bad <= n_bad + 1;
    end
    if (i_stb) begin
      if (!(i_pgm && i_hv)) begin
        n_bad <= n_bad + 1;
      end
      // Programming only pulls bits to zero
      mem[i_addr[5:0]] <= mem[i_addr[5:0]] & i_wdata;
      n_prog           <= n_prog + 1;
    end
  end
endmodule : frs_array_model
`default_nettype wire

//--- frs_pkg.sv
package frs_pkg;
  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int          ADDR_W      = 18;
  localparam logic [15:0] IDX_CTRL    = 16'hFE08;
  localparam logic [15:0] IDX_PROT    = 16'hFF81;
  localparam logic [15:0] IDX_ADDR    = 16'hFE0C;
  localparam logic [15:0] IDX_DATA    = 16'hFE0D;
  localparam logic [15:0] IDX_STAT    = 16'hFE0E;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int          CTRL_PGM    = 0;
  localparam int          CTRL_ERASE  = 1;
  localparam int          CTRL_MASS   = 2;
  localparam int          CTRL_HIGH_VOLTAGE_ENABLE   = 3;
  localparam logic [7:0]  CTRL_RST    = 8'h00;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int          STAT_PROT_RD = 0;
  localparam int          STAT_LATCHED = 1;
  localparam int          STAT_HV      = 2;
  localparam int          STAT_STBY    = 3;
  localparam int          STAT_ROW_ERR = 4;
  localparam int          STAT_REFUSED = 5;

  // ****************************************
  // Array organisation
  // ****************************************
  localparam int          ROW_SHIFT   = 6;
  localparam int          PAGE_SHIFT  = 7;
  localparam logic [15:0] MAIN_LO     = 16'h0E00;
  localparam logic [15:0] MAIN_HI     = 16'h7FFF;
  localparam logic [15:0] SMALL_LO    = 16'h0450;
  localparam logic [15:0] SMALL_HI    = 16'h05FF;
  localparam logic [7:0]  PROT_NONE   = 8'hFF;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    ST_READ,
    ST_SEL,
    ST_PROT,
    ST_LATCH,
    ST_HV,
    ST_STBY
  } frs_state_t;
endpackage : frs_pkg

//--- frs_sequencer.sv
// Operation
// - Program one 64-byte row, aligned at 00/40/80/C0 of each 256 bytes.
// - All writes of one cycle stay in one row, otherwise programming fails.
// - Setting program_select enters program mode and enables address/data latching.
// - Wait mode suspends program/erase into standby; no effect in read mode.
// - Stop mode likewise suspends program/erase into standby.
// - In standby every array control signal is inactive.
// - Erased cell reads one, programmed cell reads zero.
// - Pages of two 64-byte rows; page erases, row programs.
// - Control register at FE08, protect byte at FF81.
// - User regions 0E00-7FFF plus small region at 0450-05FF.
// - HV settable only with a select bit after the sequence; selects exclusive.
// - Refuse HV when latched address lies in the protected range.
`timescale 1ns/1ns
`default_nettype none
module frs_sequencer (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic [frs_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [frs_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  input  wire logic [7:0]                 i_protect_start,
  input  wire logic                       i_wait_mode,
  input  wire logic                       i_stop_mode,
  output logic                            o_arr_pgm,
  output logic                            o_arr_erase,
  output logic                            o_arr_mass,
  output logic                            o_arr_hv,
  output logic [15:0]                     o_arr_addr,
  output logic [7:0]                      o_arr_wdata,
  output logic                            o_arr_prog_stb,
  output logic                            o_standby
);
  import frs_pkg::*;

  // ****************************************
  // Low-power inputs
  // ****************************************
  logic wait_s;
  logic stop_s;

  frs_sync u_wait_sync (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_wait_mode), .o_sync(wait_s));
  frs_sync u_stop_sync (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_stop_mode), .o_sync(stop_s));

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic [ADDR_W-1:0] awaddr_r,  awaddr_nxt;
  logic              aw_held_r, aw_held_nxt;
  logic [7:0]        wbyte_r,   wbyte_nxt;
  logic [7:0]        wbyte1_r,  wbyte1_nxt;
  logic [1:0]        wlane_r,   wlane_nxt;
  logic              w_held_r,  w_held_nxt;
  logic              bvalid_r,  bvalid_nxt;
  logic [1:0]        bresp_r,   bresp_nxt;
  logic              awready_r, awready_nxt;
  logic              wready_r,  wready_nxt;
  logic              do_wr;
  logic [15:0]       wr_idx;
  logic              wr_hit;

  assign do_wr  = aw_held_r && w_held_r && !bvalid_r;
  assign wr_idx = awaddr_r[ADDR_W-1:2];
  assign wr_hit = (wr_idx == IDX_CTRL) || (wr_idx == IDX_ADDR) || (wr_idx == IDX_DATA)
               || (wr_idx == IDX_PROT) || (wr_idx == IDX_STAT);

  always_comb begin
    awaddr_nxt  = awaddr_r;
    aw_held_nxt = aw_held_r;
    wbyte_nxt   = wbyte_r;
    wbyte1_nxt  = wbyte1_r;
    wlane_nxt   = wlane_r;
    w_held_nxt  = w_held_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (i_awvalid && awready_r) begin
      awaddr_nxt  = i_awaddr;
      aw_held_nxt = 1'b1;
    end
    if (i_wvalid && wready_r) begin
      wbyte_nxt  = i_wdata[7:0];
      wbyte1_nxt = i_wdata[15:8];
      wlane_nxt  = i_wstrb[1:0];
      w_held_nxt = 1'b1;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      awaddr_r  <= '0;
      aw_held_r <= 1'b0;
      wbyte_r   <= 8'h00;
      wbyte1_r  <= 8'h00;
      wlane_r   <= 2'h0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      awaddr_r  <= awaddr_nxt;
      aw_held_r <= aw_held_nxt;
      wbyte_r   <= wbyte_nxt;
      wbyte1_r  <= wbyte1_nxt;
      wlane_r   <= wlane_nxt;
      w_held_r  <= w_held_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
    end
  end

  // ****************************************
  // Sequencer and array controls
  // ****************************************
  frs_state_t  state_r,    state_nxt;
  logic [7:0]  ctrl_r,     ctrl_nxt;
  logic [15:0] addr_r,     addr_nxt;
  logic [15:0] row_r,      row_nxt;
  logic        row_err_r,  row_err_nxt;
  logic        refused_r,  refused_nxt;
  logic        prot_rd_r,  prot_rd_nxt;
  logic        stb_r,      stb_nxt;
  logic [15:0] arr_addr_r, arr_addr_nxt;
  logic [7:0]  arr_wd_r,   arr_wd_nxt;
  logic        rd_prot;
  logic        wr_ctrl;
  logic        wr_data;
  logic        in_flash;
  logic        row_prot;
  logic        same_row;
  logic        lowpwr;
  logic [15:0] prot_start;
  logic [7:0]  wctl;

  assign wr_ctrl    = do_wr && (wr_idx == IDX_CTRL) && wlane_r[0];
  assign wr_data    = do_wr && (wr_idx == IDX_DATA) && wlane_r[0];
  assign lowpwr     = wait_s || stop_s;
  assign wctl       = wbyte_r;
  assign in_flash   = ((addr_r >= MAIN_LO) && (addr_r <= MAIN_HI))
                   || ((addr_r >= SMALL_LO) && (addr_r <= SMALL_HI));
  assign prot_start = {1'b0, i_protect_start, 7'h00};
  assign row_prot   = (i_protect_start != PROT_NONE) && (row_r >= prot_start);
  assign same_row   = (addr_r[15:ROW_SHIFT] == row_r[15:ROW_SHIFT]);

  always_comb begin
    state_nxt    = state_r;
    ctrl_nxt     = ctrl_r;
    addr_nxt     = addr_r;
    row_nxt      = row_r;
    row_err_nxt  = row_err_r;
    refused_nxt  = refused_r;
    prot_rd_nxt  = prot_rd_r;
    stb_nxt      = 1'b0;
    arr_addr_nxt = arr_addr_r;
    arr_wd_nxt   = arr_wd_r;
    if (do_wr && (wr_idx == IDX_ADDR)) begin
      if (wlane_r[0]) addr_nxt[7:0] = wbyte_r;
      if (wlane_r[1]) addr_nxt[15:8] = wbyte1_r;
    end
    if (wr_ctrl) begin
      ctrl_nxt[CTRL_MASS] = wctl[CTRL_MASS];
      // A request for both selects, or for the other one, leaves both selects clear
      if (wctl[CTRL_PGM] && wctl[CTRL_ERASE]) begin
        ctrl_nxt[CTRL_PGM]   = 1'b0;
        ctrl_nxt[CTRL_ERASE] = 1'b0;
      end else begin
        ctrl_nxt[CTRL_PGM]   = wctl[CTRL_PGM] && !ctrl_r[CTRL_ERASE];
        ctrl_nxt[CTRL_ERASE] = wctl[CTRL_ERASE] && !ctrl_r[CTRL_PGM];
      end
      if (!wctl[CTRL_HIGH_VOLTAGE_ENABLE]) begin
        ctrl_nxt[CTRL_HIGH_VOLTAGE_ENABLE] = 1'b0;
      end else if (!ctrl_r[CTRL_HIGH_VOLTAGE_ENABLE]) begin
        if ((state_r == ST_LATCH) && (ctrl_r[CTRL_PGM] || ctrl_r[CTRL_ERASE])
            && !row_prot) begin
          ctrl_nxt[CTRL_HIGH_VOLTAGE_ENABLE] = 1'b1;
        end else begin
          refused_nxt = 1'b1;
        end
      end
    end
    case (state_r)
      ST_READ: begin
        if (ctrl_nxt[CTRL_PGM] || ctrl_nxt[CTRL_ERASE]) begin
          state_nxt   = ST_SEL;
          prot_rd_nxt = 1'b0;
          row_err_nxt = 1'b0;
          refused_nxt = wr_ctrl && wctl[CTRL_HIGH_VOLTAGE_ENABLE];
        end
      end
      ST_SEL: begin
        if (rd_prot) state_nxt = ST_PROT;
      end
      ST_PROT: begin
        if (wr_data && in_flash) begin
          row_nxt   = addr_r;
          state_nxt = ST_LATCH;
        end
      end
      ST_LATCH: begin
        if (ctrl_nxt[CTRL_HIGH_VOLTAGE_ENABLE]) state_nxt = ST_HV;
      end
      ST_HV: begin
        if (wr_data && ctrl_r[CTRL_PGM]) begin
          if (same_row && in_flash && !row_err_r) begin
            stb_nxt      = 1'b1;
            arr_addr_nxt = addr_r;
            arr_wd_nxt   = wbyte_r;
          end else begin
            row_err_nxt = 1'b1;
          end
        end
        if (!ctrl_nxt[CTRL_HIGH_VOLTAGE_ENABLE]) state_nxt = ST_SEL;
      end
      ST_STBY: begin
        if (!lowpwr && !ctrl_r[CTRL_PGM] && !ctrl_r[CTRL_ERASE] && !ctrl_r[CTRL_HIGH_VOLTAGE_ENABLE])
          state_nxt = ST_READ;
      end
      default: state_nxt = ST_READ;
    endcase
    if ((state_r != ST_READ) && (state_r != ST_STBY)) begin
      if (lowpwr) begin
        state_nxt = ST_STBY;
        stb_nxt   = 1'b0;
      end else if (!ctrl_nxt[CTRL_PGM] && !ctrl_nxt[CTRL_ERASE] && !ctrl_nxt[CTRL_HIGH_VOLTAGE_ENABLE]) begin
        state_nxt = ST_READ;
      end
    end
    if (state_nxt == ST_READ) ctrl_nxt[CTRL_HIGH_VOLTAGE_ENABLE] = 1'b0;
    if (rd_prot) prot_rd_nxt = 1'b1;
    if (state_nxt == ST_LATCH || state_nxt == ST_HV) begin
      if (state_nxt == ST_HV && ctrl_nxt[CTRL_ERASE])
        arr_addr_nxt = {row_r[15:PAGE_SHIFT], 7'h00};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r    <= ST_READ;
      ctrl_r     <= CTRL_RST;
      addr_r     <= 16'h0000;
      row_r      <= 16'h0000;
      row_err_r  <= 1'b0;
      refused_r  <= 1'b0;
      prot_rd_r  <= 1'b0;
      stb_r      <= 1'b0;
      arr_addr_r <= 16'h0000;
      arr_wd_r   <= ERASED_BYTE;
    end else begin
      state_r    <= state_nxt;
      ctrl_r     <= ctrl_nxt;
      addr_r     <= addr_nxt;
      row_r      <= row_nxt;
      row_err_r  <= row_err_nxt;
      refused_r  <= refused_nxt;
      prot_rd_r  <= prot_rd_nxt;
      stb_r      <= stb_nxt;
      arr_addr_r <= arr_addr_nxt;
      arr_wd_r   <= arr_wd_nxt;
    end
  end

  // Array drives, all but standby quiet outside an active step
  logic active;
  logic pgm_o_r, era_o_r, mass_o_r, hv_o_r, stby_o_r;

  assign active = (state_r == ST_LATCH) || (state_r == ST_HV);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pgm_o_r  <= 1'b0;
      era_o_r  <= 1'b0;
      mass_o_r <= 1'b0;
      hv_o_r   <= 1'b0;
      stby_o_r <= 1'b0;
    end else begin
      pgm_o_r  <= active && ctrl_r[CTRL_PGM];
      era_o_r  <= active && ctrl_r[CTRL_ERASE];
      mass_o_r <= active && ctrl_r[CTRL_MASS];
      hv_o_r   <= (state_r == ST_HV) && ctrl_r[CTRL_HIGH_VOLTAGE_ENABLE];
      stby_o_r <= (state_r == ST_STBY);
    end
  end

  assign o_arr_pgm      = pgm_o_r;
  assign o_arr_erase    = era_o_r;
  assign o_arr_mass     = mass_o_r;
  assign o_arr_hv       = hv_o_r;
  assign o_arr_addr     = arr_addr_r;
  assign o_arr_wdata    = arr_wd_r;
  assign o_arr_prog_stb = stb_r;
  assign o_standby      = stby_o_r;
  assign o_awready      = awready_r;
  assign o_wready       = wready_r;
  assign o_bvalid       = bvalid_r;
  assign o_bresp        = bresp_r;

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic        rvalid_r,  rvalid_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rd_take;
  logic [15:0] rd_idx;
  logic [7:0]  stat_val;

  assign rd_take  = i_arvalid && arready_r;
  assign rd_idx   = i_araddr[ADDR_W-1:2];
  assign rd_prot  = rd_take && (rd_idx == IDX_PROT);
  assign stat_val = {2'b00, refused_r, row_err_r, (state_r == ST_STBY),
                     ctrl_r[CTRL_HIGH_VOLTAGE_ENABLE], (state_r == ST_LATCH || state_r == ST_HV),
                     prot_rd_r};

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (rd_idx)
        IDX_CTRL: rdata_nxt = {24'h00_0000, ctrl_r};
        IDX_PROT: rdata_nxt = {24'h00_0000, i_protect_start};
        IDX_ADDR: rdata_nxt = {16'h0000, addr_r};
        IDX_DATA: rdata_nxt = {24'h00_0000, arr_wd_r};
        IDX_STAT: rdata_nxt = {24'h00_0000, stat_val};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_DECERR;
        end
      endcase
    end else if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
    end else begin
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign o_arready = arready_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence lp_req_s;
    lowpwr && (state_r != ST_READ) && (state_r != ST_STBY);
  endsequence
  sequence quiet_s;
    o_standby && !o_arr_hv && !o_arr_pgm && !o_arr_erase;
  endsequence

  select_excl_a: assert property (!(ctrl_r[CTRL_PGM] && ctrl_r[CTRL_ERASE]))
    else $error("program and erase selects both set");
  hv_grant_a: assert property ($rose(ctrl_r[CTRL_HIGH_VOLTAGE_ENABLE]) |->
      $past(state_r) == ST_LATCH && (ctrl_r[CTRL_PGM] || ctrl_r[CTRL_ERASE]))
    else $error("high voltage granted out of sequence");
  prot_refuse_a: assert property (wr_ctrl && wctl[CTRL_HIGH_VOLTAGE_ENABLE] && row_prot
      && !ctrl_r[CTRL_HIGH_VOLTAGE_ENABLE] |=> !ctrl_r[CTRL_HIGH_VOLTAGE_ENABLE] && refused_r)
    else $error("high voltage granted on protected row");
  row_stb_a: assert property (o_arr_prog_stb |->
      o_arr_addr[15:ROW_SHIFT] == row_r[15:ROW_SHIFT] && o_arr_hv)
    else $error("program strobe outside latched row");
  row_err_a: assert property (state_r == ST_HV && wr_data && ctrl_r[CTRL_PGM]
      && !same_row && !lowpwr |=> row_err_r && !o_arr_prog_stb)
    else $error("cross-row write not flagged");
  lp_stby_a: assert property (lp_req_s |=> ##1 quiet_s)
    else $error("low power did not reach standby");
  stby_quiet_a: assert property (state_r == ST_STBY |=> quiet_s)
    else $error("array control active in standby");
  read_mode_a: assert property (state_r == ST_READ && lowpwr
      && !ctrl_nxt[CTRL_PGM] && !ctrl_nxt[CTRL_ERASE] |=> state_r == ST_READ)
    else $error("low power disturbed read mode");
  wr_resp_a: assert property (do_wr |=> o_bvalid && !o_awready)
    else $error("write response not one cycle after both channels");
  pgm_latch_a: assert property (state_r == ST_READ && wr_ctrl
      && wctl[CTRL_PGM] && !wctl[CTRL_ERASE] && !lowpwr |=> state_r == ST_SEL ##1 o_arr_pgm == 1'b0)
    else $error("program select not entered");
endmodule : frs_sequencer
`default_nettype wire

//--- frs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module frs_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : frs_sync
`default_nettype wire

//--- tb_flash_row_program_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_flash_row_program_sequencer;
  import frs_pkg::*;
  // ****
  // Signals
  // ****
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic [31:0]       i_wdata, o_rdata, x, rs;
  logic [3:0]        i_wstrb;
  logic [1:0]        o_bresp, o_rresp;
  logic [15:0]       o_arr_addr, row;
  logic [7:0]        o_arr_wdata, prot, prot_start;
  logic [7:0]        dat [8];
  logic [5:0]        offs [8];
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_wait_mode, i_stop_mode;
  logic o_arr_pgm, o_arr_erase, o_arr_mass, o_arr_hv, o_arr_prog_stb, o_standby;
  int   n_errors, check_count, t;
  localparam logic [17:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [17:0] A_PROT = {IDX_PROT, 2'b00};
  localparam logic [17:0] A_ADDR = {IDX_ADDR, 2'b00};
  localparam logic [17:0] A_DATA = {IDX_DATA, 2'b00};
  localparam logic [17:0] A_STAT = {IDX_STAT, 2'b00};
  localparam logic [17:0] A_BAD  = 18'h0_1000;
  localparam logic [7:0]  TP [5] = '{8'hFE, 8'hFE, 8'h00, 8'hFF, 8'hFF};
  localparam logic [15:0] TR [5] = '{16'h7F00, 16'h7EC0, 16'h0E00, 16'h8000, 16'h0480};

  frs_sequencer i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_protect_start(prot_start), .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode),
    .o_arr_pgm(o_arr_pgm), .o_arr_erase(o_arr_erase), .o_arr_mass(o_arr_mass),
    .o_arr_hv(o_arr_hv), .o_arr_addr(o_arr_addr), .o_arr_wdata(o_arr_wdata),
    .o_arr_prog_stb(o_arr_prog_stb), .o_standby(o_standby)
  );

  frs_array_model i_model (
    .i_clk(i_clk), .i_pgm(o_arr_pgm), .i_erase(o_arr_erase), .i_hv(o_arr_hv),
    .i_addr(o_arr_addr), .i_wdata(o_arr_wdata), .i_stb(o_arr_prog_stb),
    .i_standby(o_standby), .i_prot(prot), .o_protect_start(prot_start)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  // High voltage is granted for an in-flash row below the protect start
  function automatic logic exp_hv(input logic [7:0] p, input logic [15:0] a);
    logic fl;
    fl = (a >= MAIN_LO && a <= MAIN_HI) || (a >= SMALL_LO && a <= SMALL_HI);
    return fl && ((p == PROT_NONE) || (a < {1'b0, p, 7'h00}));
  endfunction : exp_hv

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    t = 0;
    do begin
      @(posedge i_clk);
      t++;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, o_bresp});
    i_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er, input string nm);
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    t = 0;
    do begin
      @(posedge i_clk);
      t++;
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    chk(nm, e, o_rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, o_rresp});
    i_rready <= 1'b0;
  endtask : rd

  task automatic arm(input logic [7:0] p, input logic [15:0] r);
    prot <= p;
    wr(A_CTRL, 32'h1, RESP_OKAY);
    rd(A_PROT, {24'h0, p}, 32'hFF, RESP_OKAY, "protect");
    wr(A_ADDR, {16'h0, r}, RESP_OKAY);
    wr(A_DATA, rnd(), RESP_OKAY);
    wr(A_CTRL, 32'h9, RESP_OKAY);
    repeat (2) @(posedge i_clk);
    chk("hv", {31'h0, exp_hv(p, r)}, {31'h0, o_arr_hv});
    rd(A_STAT, exp_hv(p, r) ? 32'h04 : 32'h20, 32'h24, RESP_OKAY, "stat");
  endtask : arm

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    $display("watchdog expired");
    results();
  end

  // ****
  // Tests
  // ****
  initial begin
    {i_awaddr, i_araddr, i_wdata, i_awvalid, i_wvalid, i_bready} = '0;
    {i_arvalid, i_rready, i_wait_mode, i_stop_mode} = '0;
    i_wstrb     = 4'hF;
    prot        = PROT_NONE;
    rs          = 32'hbbb7_9349;
    n_errors    = 0;
    check_count = 0;
    i_rst       = 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd(A_CTRL, {24'h0, CTRL_RST}, 32'hFF, RESP_OKAY, "ctrl_reset");
    rd(A_BAD, 32'h0, 32'hFFFF_FFFF, RESP_DECERR, "unmapped");
    wr(A_BAD, 32'h0, RESP_DECERR);
    wr(A_PROT, 32'h0, RESP_OKAY);
    rd(A_PROT, {24'h0, PROT_NONE}, 32'hFF, RESP_OKAY, "protect_ro");
    wr(A_CTRL, 32'h3, RESP_OKAY);
    rd(A_CTRL, 32'h0, 32'h3, RESP_OKAY, "interlock");
    wr(A_CTRL, 32'h8, RESP_OKAY);
    rd(A_CTRL, 32'h0, 32'h8, RESP_OKAY, "hv_no_select");
    $display("register test done");
    x   = rnd();
    row = MAIN_LO + (x[15:0] & 16'h6FC0);
    arm(PROT_NONE, row);
    for (int k = 0; k < 8; k++) begin
      x       = rnd();
      offs[k] = (k == 7) ? 6'h3F : {k[2:0], x[10:8]};
      dat[k]  = x[7:0];
      wr(A_ADDR, {16'h0, row + {10'h0, offs[k]}}, RESP_OKAY);
      wr(A_DATA, {24'h0, dat[k]}, RESP_OKAY);
      repeat (3) @(posedge i_clk);
    end
    chk("prog_count", 32'd8, i_model.n_prog);
    for (int k = 0; k < 8; k++) begin
      chk("cell", {24'h0, dat[k]}, {24'h0, i_model.mem[offs[k]]});
    end
    wr(A_ADDR, {16'h0, row + 16'h0040}, RESP_OKAY);
    wr(A_DATA, 32'h0, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    chk("out_of_row", 32'd8, i_model.n_prog);
    rd(A_STAT, 32'h10, 32'h10, RESP_OKAY, "row_err");
    wr(A_CTRL, 32'h8, RESP_OKAY);
    wr(A_CTRL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge i_clk);
    chk("done_ctrl", 32'h0, {30'h0, o_arr_hv, o_arr_pgm});
    $display("row program test done");
    for (int k = 0; k < 5; k++) begin
      arm(TP[k], TR[k]);
      wr(A_CTRL, 32'h0, RESP_OKAY);
    end
    $display("protect test done");
    wr(A_CTRL, 32'h6, RESP_OKAY);
    rd(A_PROT, {24'h0, PROT_NONE}, 32'hFF, RESP_OKAY, "protect_erase");
    wr(A_ADDR, {16'h0, row + 16'h0055}, RESP_OKAY);
    rd(A_ADDR, {16'h0, row + 16'h0055}, 32'hFFFF, RESP_OKAY, "addr_readback");
    wr(A_DATA, rnd(), RESP_OKAY);
    wr(A_CTRL, 32'hE, RESP_OKAY);
    repeat (2) @(posedge i_clk);
    chk("erase_ctl", 32'hB, {28'h0, o_arr_hv, o_arr_pgm, o_arr_erase, o_arr_mass});
    chk("erase_page", {16'h0, (row + 16'h0055) & 16'hFF80}, {16'h0, o_arr_addr});
    wr(A_CTRL, 32'hD, RESP_OKAY);
    rd(A_CTRL, 32'h0, 32'h3, RESP_OKAY, "select_interlock");
    wr(A_CTRL, 32'h0, RESP_OKAY);
    $display("erase test done");
    for (int m = 0; m < 2; m++) begin
      arm(PROT_NONE, row);
      i_wait_mode <= (m == 0);
      i_stop_mode <= (m == 1);
      t = 0;
      while (o_standby !== 1'b1 && t < 10) begin
        @(posedge i_clk);
        t++;
      end
      chk("standby", 32'h1, {31'h0, o_standby});
      chk("stby_ctl", 32'h0, {28'h0, o_arr_hv, o_arr_pgm, o_arr_erase, o_arr_mass});
      i_wait_mode <= 1'b0;
      i_stop_mode <= 1'b0;
      wr(A_CTRL, 32'h0, RESP_OKAY);
      repeat (4) @(posedge i_clk);
      chk("stby_exit", 32'h0, {31'h0, o_standby});
    end
    i_wait_mode <= 1'b1;
    i_stop_mode <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("read_mode", 32'h0, {31'h0, o_standby});
    chk("model", 32'h0, i_model.n_bad);
    $display("low power test done");
    results();
  end
endmodule : tb_flash_row_program_sequencer
`default_nettype wire
